// ==== hdl/cfg_field_split.v ====
// Splits a selector word into target fields
`timescale 1ns/10ps
`include "cfg_port_defs.vh"
module cfg_field_split (
  input  wire [31:0] selector,
  output wire        enable,
  output wire [7:0]  busNum,
  output wire [4:0]  devNum,
  output wire [2:0]  fnNum,
  output wire [5:0]  regNum
);
  // Field extraction; register field sits just below the function field
  assign enable = selector[`SEL_EN_BIT];
  assign busNum = selector[`SEL_BUS_HI:`SEL_BUS_LO];
  assign devNum = selector[`SEL_DEV_HI:`SEL_DEV_LO];
  assign fnNum  = selector[`SEL_FN_HI:`SEL_FN_LO];
  assign regNum = selector[`SEL_REG_HI:`SEL_REG_LO];
endmodule // cfg_field_split

// ==== hdl/cfg_port_defs.vh ====
// Constants for the configuration I/O access port
`ifndef CFG_PORT_DEFS_VH
`define CFG_PORT_DEFS_VH
`define SEL_ADDR      16'h0cf8
`define WIN_ADDR      16'h0cfc
`define SEL_RESET     32'h00000000
`define SEL_EN_BIT    31
`define SEL_BUS_HI    23
`define SEL_BUS_LO    16
`define SEL_DEV_HI    15
`define SEL_DEV_LO    11
`define SEL_FN_HI     10
`define SEL_FN_LO     8
`define SEL_REG_HI    7
`define SEL_REG_LO    2
`endif

// ==== hdl/pci_config_io_access_port.v ====
// Configuration selector and data window decoder on the host I/O bus
// Behaviour
// - The selector register is decoded as a doubleword I/O port at 0cf8.
// - The data window is decoded as a doubleword I/O port at 0cfc.
// - After the selector is loaded with bit 31 set, each data window access runs a config transfer.
// - Byte enables on a data window access choose which bytes are transferred.
// - Only full doubleword selector accesses are claimed; others pass as plain I/O.
// - The selector is 32 bits and bits 23..16 give the bus number.
// - Bits 15..11 give the device number.
// - Bits 10..8 give the function number.
// - The register number is taken from bits 7..2, just below the function field.
`timescale 1ns/10ps
`include "cfg_port_defs.vh"
module pci_config_io_access_port (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ioValid,
  input  wire        ioWrite,
  input  wire [15:0] ioAddr,
  input  wire [3:0]  ioByteEn,
  input  wire [31:0] ioWrData,
  output wire        ioClaim,
  output wire        ioReady,
  output reg  [31:0] ioRdData,
  output wire        ioPassThru,
  output reg         cfgValid,
  output reg         cfgWrite,
  output reg  [7:0]  cfgBus,
  output reg  [4:0]  cfgDev,
  output reg  [2:0]  cfgFn,
  output reg  [5:0]  cfgReg,
  output reg  [3:0]  cfgByteEn,
  output reg  [31:0] cfgWrData,
  input  wire        cfgDone,
  input  wire [31:0] cfgRdData,
  output wire [31:0] selectorOut
);
  // One-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_CFG  = 3'b010;
  localparam ST_RESP = 3'b100;

  // Registered state and next values
  reg  [31:0] selector_q;
  reg  [31:0] selector_d;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         cfgValid_d;
  reg         cfgWrite_d;
  reg  [7:0]  cfgBus_d;
  reg  [4:0]  cfgDev_d;
  reg  [2:0]  cfgFn_d;
  reg  [5:0]  cfgReg_d;
  reg  [3:0]  cfgByteEn_d;
  reg  [31:0] cfgWrData_d;
  reg  [31:0] ioRdData_d;

  // Decoded fields and request qualifiers
  wire        selEnable;
  wire [7:0]  fBus;
  wire [4:0]  fDev;
  wire [2:0]  fFn;
  wire [5:0]  fReg;
  wire        hitSel;
  wire        hitWin;
  wire        fullDword;
  wire        selAccess;
  wire        winAccess;
  wire        isIdle;
  wire        selTake;
  wire        winTake;
  wire        cfgFinish;
  wire [31:0] laneMask;
  genvar      lane;

  // Field split of the live selector word
  cfg_field_split uSplit (
    .selector (selector_q),
    .enable   (selEnable),
    .busNum   (fBus),
    .devNum   (fDev),
    .fnNum    (fFn),
    .regNum   (fReg)
  );

  // Address decode; only full dword selector cycles are ours
  assign hitSel    = ioAddr == `SEL_ADDR;
  assign hitWin    = ioAddr == `WIN_ADDR;
  assign fullDword = ioByteEn == 4'hf;
  assign selAccess = ioValid && hitSel && fullDword;
  // Window claimed only when the selector enables config cycles
  assign winAccess = ioValid && hitWin && selEnable;
  // Busy sequencer refuses new work; the host keeps its request up
  assign isIdle      = state_q == ST_IDLE;
  assign ioClaim     = (selAccess || winAccess) && isIdle;
  assign ioPassThru  = ioValid && !(selAccess || winAccess);
  assign ioReady     = state_q == ST_RESP;
  assign selectorOut = selector_q;

  // Accepted requests of each kind
  assign selTake   = ioClaim && selAccess;
  assign winTake   = ioClaim && winAccess;
  assign cfgFinish = state_q == ST_CFG && cfgDone;

  // Lane mask; unselected lanes of a read come back as zero
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
      assign laneMask[lane*8 +: 8] = {8{cfgByteEn[lane]}};
    end
  endgenerate

  // Selector next value; bits 1..0 are never stored
  always @* begin
    selector_d = selector_q;
    if (selTake && ioWrite) begin
      selector_d = {ioWrData[31:2], 2'b00};
    end
  end

  // Selector register; cleared on reset so config cycles start disabled
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selector_q <= `SEL_RESET;
    end else begin
      selector_q <= selector_d;
    end
  end

  // Next state; one access in flight at a time
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (selTake) begin
          state_d = ST_RESP;
        end else if (winTake) begin
          state_d = ST_CFG;
        end
      end
      ST_CFG: begin
        // Waits on the target side; no time limit on its answer
        if (cfgDone) begin
          state_d = ST_RESP;
        end
      end
      ST_RESP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Transfer request fields; frozen while the target works on them
  always @* begin
    cfgValid_d  = cfgValid;
    cfgWrite_d  = cfgWrite;
    cfgBus_d    = cfgBus;
    cfgDev_d    = cfgDev;
    cfgFn_d     = cfgFn;
    cfgReg_d    = cfgReg;
    cfgByteEn_d = cfgByteEn;
    cfgWrData_d = cfgWrData;
    if (winTake) begin
      cfgValid_d  = 1'b1;
      cfgWrite_d  = ioWrite;
      cfgBus_d    = fBus;
      cfgDev_d    = fDev;
      cfgFn_d     = fFn;
      cfgReg_d    = fReg;
      cfgByteEn_d = ioByteEn;
      cfgWrData_d = ioWrData;
    end else if (cfgFinish) begin
      cfgValid_d  = 1'b0;
    end
  end

  // Read data; a write leaves the last read value standing
  always @* begin
    ioRdData_d = ioRdData;
    if (selTake && !ioWrite) begin
      ioRdData_d = selector_q;
    end else if (cfgFinish && !cfgWrite) begin
      ioRdData_d = cfgRdData & laneMask;
    end
  end

  // Sequencer state register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request register toward the config target
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgValid  <= 1'b0;
      cfgWrite  <= 1'b0;
      cfgBus    <= 8'h00;
      cfgDev    <= 5'h00;
      cfgFn     <= 3'h0;
      cfgReg    <= 6'h00;
      cfgByteEn <= 4'h0;
      cfgWrData <= 32'h00000000;
    end else begin
      cfgValid  <= cfgValid_d;
      cfgWrite  <= cfgWrite_d;
      cfgBus    <= cfgBus_d;
      cfgDev    <= cfgDev_d;
      cfgFn     <= cfgFn_d;
      cfgReg    <= cfgReg_d;
      cfgByteEn <= cfgByteEn_d;
      cfgWrData <= cfgWrData_d;
    end
  end

  // Read data register; holds until the next read completes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ioRdData <= 32'h00000000;
    end else begin
      ioRdData <= ioRdData_d;
    end
  end
endmodule // pci_config_io_access_port

// ==== testbench/cfg_port_checker.sv ====
// Assertions on the config access port
`timescale 1ns/10ps
module cfg_port_checker (
  input wire        clk,
  input wire        reset_n,
  input wire        ioValid,
  input wire        ioWrite,
  input wire        ioClaim,
  input wire        ioReady,
  input wire        ioPassThru,
  input wire        cfgValid,
  input wire        cfgDone,
  input wire [15:0] ioAddr,
  input wire [3:0]  ioByteEn,
  input wire [3:0]  cfgByteEn,
  input wire [31:0] ioWrData,
  input wire [31:0] selectorOut,
  input wire [7:0]  cfgBus,
  input wire [4:0]  cfgDev,
  input wire [2:0]  cfgFn,
  input wire [5:0]  cfgReg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Selector and window hits
  wire s = ioAddr == 16'h0cf8, w = ioAddr == 16'h0cfc;
  other_pass_a: assert property (ioValid && ioAddr[15:3] != 13'h19f |-> ioPassThru)
    else $error("foreign claim");
  narrow_sel_a: assert property (ioValid && s && ~&ioByteEn |-> ioPassThru)
    else $error("narrow claim");
  sel_ready_a: assert property (ioClaim && s |=> ioReady) else $error("no answer");
  sel_store_a: assert property (ioClaim && s && ioWrite
    |=> selectorOut == ($past(ioWrData) & 32'hfffffffc)) else $error("not stored");
  win_start_a: assert property (ioClaim && w |=> cfgValid && cfgByteEn == $past(ioByteEn))
    else $error("bad start");
  win_off_a: assert property (ioValid && w && !selectorOut[31] |-> ioPassThru)
    else $error("disabled claim");
  field_map_a: assert property (cfgValid
    |-> {cfgBus, cfgDev, cfgFn, cfgReg} == selectorOut[23:2]) else $error("bad fields");
  win_done_a: assert property (cfgValid && cfgDone |=> ioReady && !cfgValid)
    else $error("bad finish");
  busy_refuse_a: assert property (cfgValid || ioReady |-> !ioClaim)
    else $error("claim while busy");
  sel_claim_a: assert property (ioValid && s && &ioByteEn && !cfgValid && !ioReady
    |-> ioClaim) else $error("full access refused");
  sel_reset_a: assert property ($rose(reset_n) |-> selectorOut == 32'h0)
    else $error("selector not cleared");
endmodule // cfg_port_checker
bind pci_config_io_access_port cfg_port_checker chk_u (
  .clk         (clk),
  .reset_n     (reset_n),
  .ioValid     (ioValid),
  .ioWrite     (ioWrite),
  .ioClaim     (ioClaim),
  .ioReady     (ioReady),
  .ioPassThru  (ioPassThru),
  .cfgValid    (cfgValid),
  .cfgDone     (cfgDone),
  .ioAddr      (ioAddr),
  .ioByteEn    (ioByteEn),
  .cfgByteEn   (cfgByteEn),
  .ioWrData    (ioWrData),
  .selectorOut (selectorOut),
  .cfgBus      (cfgBus),
  .cfgDev      (cfgDev),
  .cfgFn       (cfgFn),
  .cfgReg      (cfgReg)
);

// ==== testbench/cfg_target_model.sv ====
// Config target model answering after a random wait
`timescale 1ns/10ps
module cfg_target_model (
  input wire clk, cfgValid,
  input wire [21:0] tgt,
  output reg cfgDone = 1'b0,
  output wire [31:0] cfgRdData);
  integer seed = 36;
  // Inverted outside done so stale data shows
  assign cfgRdData = {32{~cfgDone}} ^ {tgt, 10'h2a5};
  // One done pulse per transfer after a random wait
  always @(posedge clk) cfgDone <= cfgValid && !cfgDone && $random(seed) % 3 == 0;
endmodule // cfg_target_model

// ==== testbench/tb_top.sv ====
// Bench for the config access port
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0, reset_n = 1'b0, ioValid = 1'b0, ioWrite = 1'b0;
  reg [15:0] ioAddr = 16'h0;
  reg [3:0] ioByteEn = 4'h0, b;
  reg [31:0] ioWrData = 32'h0, s, p = 32'h0, m, q[$];
  reg [36:0] x, t[$];
  wire ioClaim, ioReady, ioPassThru, cfgValid, cfgWrite, cfgDone;
  wire [7:0] cfgBus;
  wire [4:0] cfgDev;
  wire [2:0] cfgFn;
  wire [5:0] cfgReg;
  wire [3:0] cfgByteEn;
  wire [31:0] ioRdData, cfgWrData, cfgRdData, selectorOut;
  integer n_errors = 0, checks = 0, seed = 36, i;
  pci_config_io_access_port dut_u (
    .clk         (clk),
    .reset_n     (reset_n),
    .ioValid     (ioValid),
    .ioWrite     (ioWrite),
    .ioAddr      (ioAddr),
    .ioByteEn    (ioByteEn),
    .ioWrData    (ioWrData),
    .ioClaim     (ioClaim),
    .ioReady     (ioReady),
    .ioRdData    (ioRdData),
    .ioPassThru  (ioPassThru),
    .cfgValid    (cfgValid),
    .cfgWrite    (cfgWrite),
    .cfgBus      (cfgBus),
    .cfgDev      (cfgDev),
    .cfgFn       (cfgFn),
    .cfgReg      (cfgReg),
    .cfgByteEn   (cfgByteEn),
    .cfgWrData   (cfgWrData),
    .cfgDone     (cfgDone),
    .cfgRdData   (cfgRdData),
    .selectorOut (selectorOut)
  );
  cfg_target_model tgt_u (.clk, .cfgValid, .tgt(selectorOut[23:2]), .cfgDone, .cfgRdData);
  initial forever #2.5 clk = ~clk; // 200 MHz
  task finish_test;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Held until answered, or one cycle when passed on; sole host issues all config cycles
  task io(input w, input [15:0] a, input [3:0] e, input [31:0] d);
    begin
      @(posedge clk) #1 {ioValid, ioWrite, ioAddr, ioByteEn, ioWrData} = {1'b1, w, a, e, d};
      #1 while (ioReady !== 1'b1 && ioPassThru !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1 ioValid = 1'b0;
    end
  endtask
  // One compare per kind of result
  task check_rd(input [31:0] e);
    begin
      checks = checks + 1;
      if (ioRdData !== e) begin
        n_errors = n_errors + 1;
        $display("ERROR ioRdData expected %h seen %h", e, ioRdData);
      end
    end
  endtask
  // Write data only matters on writes
  task check_cfg(input [36:0] e);
    begin
      checks = checks + 1;
      if ({cfgWrite, cfgByteEn, cfgWrite ? cfgWrData : 32'h0} !== e) begin
        n_errors = n_errors + 1;
        $display("ERROR cfg request expected %h seen %h", e, {cfgWrite, cfgByteEn, cfgWrData});
      end
    end
  endtask
  // Each answered read takes the oldest note; sampled mid-cycle where settled
  always @(negedge clk) if (ioReady === 1'b1 && ioWrite === 1'b0) begin
    m = q.size() ? q.pop_front() : 32'hx;
    check_rd(m);
  end
  // Each finished config transfer takes the oldest transfer note
  always @(negedge clk) if (cfgValid === 1'b1 && cfgDone === 1'b1) begin
    x = t.size() ? t.pop_front() : 37'hx;
    check_cfg(x);
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      s = $random(seed) | 32'h80000003;
      b = 4'($random(seed));
      q.push_back(p);
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      io(1'b1, 16'h0cf8, 4'hf, s);
      io(1'b1, 16'h0cf8, b & 4'h7, ~s);
      p = s & 32'hfffffffc;
      q.push_back({s[23:2], 10'h2a5} & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}});
      t.push_back({1'b0, b, 32'h0});
      io(1'b0, 16'h0cfc, b, 32'h0);
      t.push_back({1'b1, b, s});
      io(1'b1, 16'h0cfc, b, s);
    end
    io(1'b1, 16'h0cf8, 4'hf, 32'h7fffffff);
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    io(1'b0, 16'h0070, 4'hf, 32'h0);
    // Mid-run reset must clear the selector again
    @(posedge clk) #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    q.push_back(32'h0);
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    n_errors = n_errors + q.size() + t.size();
    finish_test;
  end
  // Hang guard; a clean run needs well under a tenth of this span
  initial begin
    #20000 n_errors = n_errors + 1;
    finish_test;
  end
endmodule // tb_top
